//--- ghb_pkg.sv
// package for the graphics host bus interface: register map, fields,
// state types and timing constants.
// assumes a wishbone classic slave port with 32-bit data.
package ghb_pkg;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam logic [7:0] MADDR_OFF = 8'h08;
  localparam logic [7:0] MDATA_OFF = 8'h0C;
  localparam logic [7:0] MEMCFG_OFF = 8'h10;

  // ==========================================================
  // control register fields
  localparam int CTRL_WIDE_BIT = 0;
  localparam int CTRL_GO_BIT = 1;
  localparam int CTRL_WRITE_BIT = 2;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // ==========================================================
  // memory configuration fields
  localparam int MEMCFG_ILV_BIT = 0;
  localparam int MEMCFG_MEG_BIT = 1;
  localparam logic [1:0] MEMCFG_RESET = 2'h0;

  // ==========================================================
  // timing
  localparam int CLK_MHZ = 50;
  localparam int RAS_NS = 60;
  localparam int RAS_CYC = (RAS_NS * CLK_MHZ + 999) / 1000;
  localparam int CAS_NS = 40;
  localparam int CAS_CYC = (CAS_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    GHB_IDLE,
    GHB_ROW,
    GHB_COL,
    GHB_DONE
  } ghb_mem_e;

  typedef enum logic [1:0] {
    GHB_M_IDLE,
    GHB_M_REQ,
    GHB_M_CYC
  } ghb_mst_e;

endpackage

//--- ghb_host_bus.sv
// graphics host bus interface: host slave port, hold-handshake master,
// reset straps, interrupt merge and graphics memory strobes.
// assumes wishbone classic registers; pins sampled on clk_sys_i.
`timescale 1ns/1ns
`default_nettype none

module ghb_host_bus #(
  parameter int ADDR_W = 22,
  parameter int ROW_W = 9
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // wishbone classic
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // host pins
  input wire logic [ADDR_W-1:0] host_addr_i,
  output logic [ADDR_W-1:0] host_addr_o,
  output logic host_addr_oe_o,
  input wire logic [15:0] host_data_i,
  output logic [15:0] host_data_o,
  output logic host_data_oe_o,
  input wire logic byte_high_enable_n_i,
  output logic byte_high_enable_n_o,
  output logic byte_high_enable_n_oe_o,
  input wire logic mem_or_io_select_i,
  output logic mem_or_io_select_o,
  output logic mem_or_io_select_oe_o,
  input wire logic read_strobe_n_i,
  output logic read_strobe_n_o,
  input wire logic write_strobe_n_i,
  output logic write_strobe_n_o,
  output logic strobe_oe_o,
  input wire logic chip_select_n_i,
  input wire logic ready_n_i,
  input wire logic bus_hold_grant_i,
  output logic bus_hold_request_o,
  output logic master_enable_o,
  output logic slave_enable_o,
  // engines
  input wire logic drawing_engine_irq_i,
  input wire logic display_engine_irq_i,
  output logic interrupt_out_o,
  output logic sync_mode_o,
  output logic alt_cpu_style_o,
  output logic [1:0] test_mode_o,
  output logic phase2_o,
  // graphics memory
  output logic col_strobe_even_n_o,
  output logic col_strobe_odd_n_o,
  output logic [2:0] row_strobes_low_n_o,
  output logic top_addr_or_row_strobe3_o,
  output logic [ROW_W-1:0] mem_row_col_addr_o,
  output logic write_low_byte_n_o,
  output logic write_high_byte_n_o,
  output logic [1:0] bank_out_or_transfer_n_o
);

  if (ADDR_W != 22 || ROW_W != 9) begin : g_size_chk
    $error("ghb_host_bus: only 22 address and 9 row bits supported");
  end

  // ==========================================================
  // reset synchronizer and straps
  logic rst_meta_reg, rst_sync_reg, rst_seen_reg;
  always_ff @(posedge clk_sys_i) begin
    rst_meta_reg <= rst_n_i;
    rst_sync_reg <= rst_meta_reg;
  end
  wire logic rst_n = rst_sync_reg;

  logic sync_mode_reg, alt_cpu_reg, phase_reg;
  logic [1:0] test_mode_reg;
  // straps caught on the first clocked cycle after release
  always_ff @(posedge clk_sys_i) begin
    rst_seen_reg <= !rst_n;
    if (rst_seen_reg && rst_n) begin
      sync_mode_reg <= byte_high_enable_n_i;
      alt_cpu_reg <= mem_or_io_select_i;
      test_mode_reg <= {read_strobe_n_i, write_strobe_n_i};
    end else if (!rst_n) begin
      sync_mode_reg <= 1'b0;
      alt_cpu_reg <= 1'b0;
      test_mode_reg <= 2'h3;
    end
  end
  // divide by two, parked so the first cycle after reset is phase 2
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n) phase_reg <= 1'b1;
    else phase_reg <= ~phase_reg;
  end
  assign sync_mode_o = sync_mode_reg;
  assign alt_cpu_style_o = alt_cpu_reg;
  assign test_mode_o = test_mode_reg;
  assign phase2_o = phase_reg;

  // grant: one flop when synchronous, two in asynchronous mode
  logic grant_m_reg, grant_s_reg;
  always_ff @(posedge clk_sys_i) begin
    grant_m_reg <= bus_hold_grant_i;
    grant_s_reg <= grant_m_reg;
  end
  logic grant_q_reg;
  always_ff @(posedge clk_sys_i) grant_q_reg <= bus_hold_grant_i;
  wire logic grant = sync_mode_reg ? grant_q_reg : grant_s_reg;

  // ==========================================================
  // registers
  logic [15:0] ctrl_reg;
  logic [ADDR_W-1:0] maddr_reg;
  logic [15:0] mdata_reg, rdata_reg, lowbyte_reg;
  logic low_valid_reg;
  logic [1:0] memcfg_reg;
  logic irq_reg, mdone_reg;
  ghb_pkg::ghb_mst_e mst_reg;
  wire logic wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  wire logic ctrl_hit = wb_req && hit(wb_adr_i, ghb_pkg::CTRL_OFF);
  wire logic wide = ctrl_reg[ghb_pkg::CTRL_WIDE_BIT];
  wire logic go_wr = ctrl_hit && wb_we_i && wb_dat_i[ghb_pkg::CTRL_GO_BIT];

  always_ff @(posedge clk_sys_i) begin
    wb_ack_o <= wb_req;
    wb_dat_o <= 32'h0000_0000;
    if (wb_req && !wb_we_i) begin
      if (hit(wb_adr_i, ghb_pkg::CTRL_OFF))
        wb_dat_o <= {16'h0000, ctrl_reg};
      else if (hit(wb_adr_i, ghb_pkg::STAT_OFF))
        wb_dat_o <= {26'h0, test_mode_reg, alt_cpu_reg, sync_mode_reg,
                     mdone_reg, irq_reg};
      else if (hit(wb_adr_i, ghb_pkg::MADDR_OFF))
        wb_dat_o <= {10'h000, maddr_reg};
      else if (hit(wb_adr_i, ghb_pkg::MDATA_OFF))
        wb_dat_o <= {16'h0000, rdata_reg};
      else if (hit(wb_adr_i, ghb_pkg::MEMCFG_OFF))
        wb_dat_o <= {30'h0, memcfg_reg};
    end
  end

  // control: in narrow mode low byte is held until high byte arrives
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n) begin
      ctrl_reg <= ghb_pkg::CTRL_RESET;
      lowbyte_reg <= 16'h0000;
      low_valid_reg <= 1'b0;
    end else if (ctrl_hit && wb_we_i) begin
      if (wide) begin
        ctrl_reg <= wb_dat_i[15:0];
      end else if (wb_sel_i[0]) begin
        lowbyte_reg <= {8'h00, wb_dat_i[7:0]};
        low_valid_reg <= 1'b1;
      end else if (wb_sel_i[1] && low_valid_reg) begin
        ctrl_reg <= {wb_dat_i[15:8], lowbyte_reg[7:0]};
        low_valid_reg <= 1'b0;
      end
    end else if (mst_reg == ghb_pkg::GHB_M_IDLE) begin
      ctrl_reg[ghb_pkg::CTRL_GO_BIT] <= ctrl_reg[ghb_pkg::CTRL_GO_BIT]
                                        && !mdone_reg;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n) begin
      maddr_reg <= '0;
      mdata_reg <= 16'h0000;
      memcfg_reg <= ghb_pkg::MEMCFG_RESET;
    end else if (wb_req && wb_we_i) begin
      if (hit(wb_adr_i, ghb_pkg::MADDR_OFF)) maddr_reg <= wb_dat_i[21:0];
      if (hit(wb_adr_i, ghb_pkg::MDATA_OFF)) mdata_reg <= wb_dat_i[15:0];
      if (hit(wb_adr_i, ghb_pkg::MEMCFG_OFF)) memcfg_reg <= wb_dat_i[1:0];
    end
  end

  // set wins over the clear on control access
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n) irq_reg <= 1'b0;
    else if (drawing_engine_irq_i || display_engine_irq_i) irq_reg <= 1'b1;
    else if (ctrl_hit) irq_reg <= 1'b0;
  end
  assign interrupt_out_o = irq_reg;

  // ==========================================================
  // external bus master
  logic slave_busy_reg;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n) begin
      mst_reg <= ghb_pkg::GHB_M_IDLE;
      bus_hold_request_o <= 1'b0;
      master_enable_o <= 1'b0;
      mdone_reg <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      if (go_wr) mdone_reg <= 1'b0;
      case (mst_reg)
        ghb_pkg::GHB_M_IDLE: begin
          master_enable_o <= 1'b0;
          if (ctrl_reg[ghb_pkg::CTRL_GO_BIT] && !mdone_reg) begin
            bus_hold_request_o <= 1'b1;
            mst_reg <= ghb_pkg::GHB_M_REQ;
          end
        end
        ghb_pkg::GHB_M_REQ: begin
          // slave traffic keeps running meanwhile
          if (grant && !slave_busy_reg) begin
            master_enable_o <= 1'b1;
            mst_reg <= ghb_pkg::GHB_M_CYC;
          end
        end
        ghb_pkg::GHB_M_CYC: begin
          if (!grant) begin
            bus_hold_request_o <= 1'b0;
            master_enable_o <= 1'b0;
            mst_reg <= ghb_pkg::GHB_M_IDLE;
          end else if (!ready_n_i) begin
            rdata_reg <= host_data_i;
            mdone_reg <= 1'b1;
            bus_hold_request_o <= 1'b0;
            master_enable_o <= 1'b0;
            mst_reg <= ghb_pkg::GHB_M_IDLE;
          end
        end
        default: mst_reg <= ghb_pkg::GHB_M_IDLE;
      endcase
    end
  end

  // pins enable on grant while the master is out of idle and no slave cycle runs, data pins only on writes
  always_ff @(posedge clk_sys_i) begin
    host_addr_o <= maddr_reg;
    host_data_o <= mdata_reg;
    byte_high_enable_n_o <= 1'b0;
    mem_or_io_select_o <= 1'b1;
    read_strobe_n_o <= ctrl_reg[ghb_pkg::CTRL_WRITE_BIT];
    write_strobe_n_o <= !ctrl_reg[ghb_pkg::CTRL_WRITE_BIT];
    if (!rst_n) begin
      host_addr_oe_o <= 1'b0;
      host_data_oe_o <= 1'b0;
      byte_high_enable_n_oe_o <= 1'b0;
      mem_or_io_select_oe_o <= 1'b0;
      strobe_oe_o <= 1'b0;
    end else begin
      host_addr_oe_o <= grant && mst_reg != ghb_pkg::GHB_M_IDLE
                        && !slave_busy_reg;
      byte_high_enable_n_oe_o <= grant && mst_reg != ghb_pkg::GHB_M_IDLE
                                 && !slave_busy_reg;
      mem_or_io_select_oe_o <= grant && mst_reg != ghb_pkg::GHB_M_IDLE
                               && !slave_busy_reg;
      strobe_oe_o <= grant && mst_reg != ghb_pkg::GHB_M_IDLE
                     && !slave_busy_reg;
      host_data_oe_o <= grant && mst_reg != ghb_pkg::GHB_M_IDLE
                        && !slave_busy_reg
                        && ctrl_reg[ghb_pkg::CTRL_WRITE_BIT];
    end
  end

  // ==========================================================
  // slave cycle and graphics memory sequencer
  ghb_pkg::ghb_mem_e mem_reg;
  logic [3:0] cnt_reg;
  logic [ADDR_W-1:0] sl_addr_reg;
  logic sl_write_reg, sl_bhe_n_reg;
  wire logic sl_start = !chip_select_n_i
                        && (!read_strobe_n_i || !write_strobe_n_i)
                        && !grant;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n) begin
      mem_reg <= ghb_pkg::GHB_IDLE;
      cnt_reg <= 4'h0;
      slave_busy_reg <= 1'b0;
      slave_enable_o <= 1'b0;
      sl_addr_reg <= '0;
      sl_write_reg <= 1'b0;
      sl_bhe_n_reg <= 1'b1;
    end else begin
      case (mem_reg)
        ghb_pkg::GHB_IDLE: begin
          slave_enable_o <= 1'b0;
          if (sl_start && mst_reg != ghb_pkg::GHB_M_CYC) begin
            slave_busy_reg <= 1'b1;
            sl_addr_reg <= host_addr_i;
            sl_write_reg <= !write_strobe_n_i;
            sl_bhe_n_reg <= byte_high_enable_n_i;
            cnt_reg <= 4'(ghb_pkg::RAS_CYC);
            mem_reg <= ghb_pkg::GHB_ROW;
          end
        end
        ghb_pkg::GHB_ROW: begin
          cnt_reg <= cnt_reg - 4'h1;
          if (cnt_reg == 4'h1) begin
            cnt_reg <= 4'(ghb_pkg::CAS_CYC);
            mem_reg <= ghb_pkg::GHB_COL;
          end
        end
        ghb_pkg::GHB_COL: begin
          cnt_reg <= cnt_reg - 4'h1;
          if (cnt_reg == 4'h1) begin
            slave_enable_o <= 1'b1;
            mem_reg <= ghb_pkg::GHB_DONE;
          end
        end
        ghb_pkg::GHB_DONE: begin
          // hold ready until the host ends its strobe
          if (read_strobe_n_i && write_strobe_n_i) begin
            slave_enable_o <= 1'b0;
            slave_busy_reg <= 1'b0;
            mem_reg <= ghb_pkg::GHB_IDLE;
          end
        end
        default: mem_reg <= ghb_pkg::GHB_IDLE;
      endcase
    end
  end

  // address bit 1 picks the odd word bank; top bits pick the row
  wire logic odd_word = sl_addr_reg[1];
  wire logic [1:0] row_sel = sl_addr_reg[21:20];
  wire logic row_act = mem_reg != ghb_pkg::GHB_IDLE;
  wire logic col_act = mem_reg == ghb_pkg::GHB_COL
                       || mem_reg == ghb_pkg::GHB_DONE;
  wire logic ilv = memcfg_reg[ghb_pkg::MEMCFG_ILV_BIT];
  wire logic meg = memcfg_reg[ghb_pkg::MEMCFG_MEG_BIT];

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n) begin
      col_strobe_even_n_o <= 1'b1;
      col_strobe_odd_n_o <= 1'b1;
      row_strobes_low_n_o <= 3'h7;
      top_addr_or_row_strobe3_o <= 1'b1;
      mem_row_col_addr_o <= '0;
      write_low_byte_n_o <= 1'b1;
      write_high_byte_n_o <= 1'b1;
      bank_out_or_transfer_n_o <= 2'h3;
    end else begin
      col_strobe_even_n_o <= !(col_act && (!ilv || !odd_word));
      col_strobe_odd_n_o <= !(col_act && (!ilv || odd_word));
      for (int i = 0; i < 3; i++) begin
        row_strobes_low_n_o[i] <= !(row_act
                                    && row_sel == 2'(i));
      end
      if (meg)
        top_addr_or_row_strobe3_o <= col_act ? sl_addr_reg[21]
                                             : sl_addr_reg[20];
      else
        top_addr_or_row_strobe3_o <= !(row_act && row_sel == 2'h3);
      mem_row_col_addr_o <= col_act ? sl_addr_reg[10:2]
                                    : sl_addr_reg[19:11];
      write_low_byte_n_o <= !(col_act && sl_write_reg
                              && !sl_addr_reg[0]);
      write_high_byte_n_o <= !(col_act && sl_write_reg
                               && !sl_bhe_n_reg);
      bank_out_or_transfer_n_o <= {!(col_act && !sl_write_reg && odd_word),
                                   !(col_act && !sl_write_reg
                                     && !odd_word)};
    end
  end

endmodule

`default_nettype wire

//--- ghb_host_bus_sva.sv
// port-level checker for ghb_host_bus
// assumes one clock domain; bound from the testbench top file
`timescale 1ns/1ns
`default_nettype none
module ghb_host_bus_sva (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic chip_select_n_i,
  input wire logic read_strobe_n_i,
  input wire logic write_strobe_n_i,
  input wire logic bus_hold_grant_i,
  input wire logic bus_hold_request_o,
  input wire logic master_enable_o,
  input wire logic slave_enable_o,
  input wire logic host_addr_oe_o,
  input wire logic strobe_oe_o,
  input wire logic drawing_engine_irq_i,
  input wire logic display_engine_irq_i,
  input wire logic interrupt_out_o,
  input wire logic phase2_o,
  input wire logic sync_mode_o,
  input wire logic alt_cpu_style_o
);
  // ==========================================================
  // cycles since reset release; the inner synchroniser lags
  logic [2:0] up_cnt;
  logic irq_any;
  assign irq_any = drawing_engine_irq_i || display_engine_irq_i;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      up_cnt <= 3'h0;
    end else if (up_cnt != 3'h7) begin
      up_cnt <= up_cnt + 3'h1;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================================
  // assertions
  a_ack_answer: assert property (wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged next cycle");
  a_men_sen_excl: assert property (!(master_enable_o && slave_enable_o))
    else $error("master and slave enable high together");
  a_men_after_grant: assert property ($rose(master_enable_o) |->
    bus_hold_request_o && $past(bus_hold_grant_i))
    else $error("master enable without grant");
  a_slave_no_drive: assert property (slave_enable_o |->
    !host_addr_oe_o && !strobe_oe_o)
    else $error("pins driven during slave cycle");
  a_req_drop: assert property (bus_hold_request_o &&
    $fell(bus_hold_grant_i) |-> ##[0:4] !bus_hold_request_o)
    else $error("request kept after grant loss");
  a_irq_follow: assert property (irq_any |-> ##[1:3] interrupt_out_o)
    else $error("engine interrupt not merged");
  a_irq_cause: assert property ($rose(interrupt_out_o) |->
    $past(irq_any) || $past(irq_any, 2) || $past(irq_any, 3))
    else $error("interrupt without engine cause");
  a_sen_cause: assert property ($rose(slave_enable_o) |->
    $past(!chip_select_n_i, 3))
    else $error("slave enable without chip select");
  a_sen_release: assert property (slave_enable_o && read_strobe_n_i &&
    write_strobe_n_i |-> ##[0:4] !slave_enable_o)
    else $error("slave enable kept after strobes ended");
  a_phase_toggle: assert property (up_cnt == 3'h7 |->
    phase2_o != $past(phase2_o))
    else $error("internal clock not divided by two");
  a_strap_hold: assert property (up_cnt == 3'h7 |->
    $stable(sync_mode_o) && $stable(alt_cpu_style_o))
    else $error("strap selection changed outside reset");
  c_master: cover property ($rose(master_enable_o));
  c_slave: cover property ($rose(slave_enable_o));
  c_irq: cover property ($fell(interrupt_out_o));
endmodule
`default_nettype wire

//--- ghb_host_model.sv
// far side model: hold arbiter and ready source of the shared bus
// assumes request and master enable are registered levels
`timescale 1ns/1ns
`default_nettype none
module ghb_host_model (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic bus_hold_request_i,
  input wire logic master_enable_i,
  input wire logic withhold_i,
  input wire logic drop_grant_i,
  input wire logic [3:0] grant_delay_i,
  output logic bus_hold_grant_o,
  output logic ready_n_o
);
  // ==========================================================
  // grant after a programmable wait; withdrawn on command
  logic [3:0] req_cnt;
  logic [3:0] men_cnt;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !bus_hold_request_i) begin
      req_cnt <= 4'h0;
      bus_hold_grant_o <= 1'b0;
    end else begin
      if (req_cnt != 4'hF) req_cnt <= req_cnt + 4'h1;
      bus_hold_grant_o <= !withhold_i && !drop_grant_i &&
        (req_cnt >= grant_delay_i || bus_hold_grant_o);
    end
  end
  // ready held low from the fourth master cycle until release
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !master_enable_i) begin
      men_cnt <= 4'h0;
      ready_n_o <= 1'b1;
    end else begin
      if (men_cnt != 4'hF) men_cnt <= men_cnt + 4'h1;
      ready_n_o <= !(men_cnt >= 4'h2 && !drop_grant_i);
    end
  end
endmodule
`default_nettype wire

//--- testbench.sv
// self-checking bench for ghb_host_bus: straps, register bus,
// hold handshake, slave cycles and interrupt merge
// assumes ghb_host_model on the far side and the checker bound below
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk_sys_i = 1'b0, rst_n_i = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [21:0] addr_drv = 22'h0, host_addr_o;
  logic [15:0] host_data_o;
  logic bhe_drv = 1'b1, mio_drv = 1'b0, rd_drv = 1'b1, wr_drv = 1'b1;
  logic chip_select_n_i = 1'b1, withhold = 1'b0, drop_grant = 1'b0;
  logic drawing_engine_irq_i = 1'b0, display_engine_irq_i = 1'b0;
  logic [3:0] grant_delay = 4'h3;
  logic host_addr_oe_o, host_data_oe_o, byte_high_enable_n_o;
  logic byte_high_enable_n_oe_o, mem_or_io_select_o, mem_or_io_select_oe_o;
  logic read_strobe_n_o, write_strobe_n_o, strobe_oe_o, ready_n_i;
  logic bus_hold_grant_i, bus_hold_request_o, master_enable_o;
  logic slave_enable_o, interrupt_out_o, sync_mode_o, alt_cpu_style_o;
  logic phase2_o, col_strobe_even_n_o, col_strobe_odd_n_o;
  logic write_low_byte_n_o, write_high_byte_n_o;
  logic [1:0] bank_out_or_transfer_n_o;
  logic [2:0] row_strobes_low_n_o;
  int n_errors = 0, checked = 0, cycles = 0;
  // ==========================================================
  // pin levels from every party's enable
  wire [21:0] addr_w = host_addr_oe_o ? host_addr_o : addr_drv;
  wire [15:0] data_w = host_data_oe_o ? host_data_o : 16'h5AA5;
  wire bhe_w = byte_high_enable_n_oe_o ? byte_high_enable_n_o : bhe_drv;
  wire mio_w = mem_or_io_select_oe_o ? mem_or_io_select_o : mio_drv;
  wire rd_w = strobe_oe_o ? read_strobe_n_o : rd_drv;
  wire wr_w = strobe_oe_o ? write_strobe_n_o : wr_drv;
  always #10 clk_sys_i = ~clk_sys_i;
  ghb_host_bus i_dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .host_addr_i(addr_w), .host_addr_o(host_addr_o),
    .host_addr_oe_o(host_addr_oe_o), .host_data_i(data_w),
    .host_data_o(host_data_o), .host_data_oe_o(host_data_oe_o),
    .byte_high_enable_n_i(bhe_w),
    .byte_high_enable_n_o(byte_high_enable_n_o),
    .byte_high_enable_n_oe_o(byte_high_enable_n_oe_o),
    .mem_or_io_select_i(mio_w), .mem_or_io_select_o(mem_or_io_select_o),
    .mem_or_io_select_oe_o(mem_or_io_select_oe_o),
    .read_strobe_n_i(rd_w), .read_strobe_n_o(read_strobe_n_o),
    .write_strobe_n_i(wr_w), .write_strobe_n_o(write_strobe_n_o),
    .strobe_oe_o(strobe_oe_o), .chip_select_n_i(chip_select_n_i),
    .ready_n_i(ready_n_i), .bus_hold_grant_i(bus_hold_grant_i),
    .bus_hold_request_o(bus_hold_request_o),
    .master_enable_o(master_enable_o), .slave_enable_o(slave_enable_o),
    .drawing_engine_irq_i(drawing_engine_irq_i),
    .display_engine_irq_i(display_engine_irq_i),
    .interrupt_out_o(interrupt_out_o), .sync_mode_o(sync_mode_o),
    .alt_cpu_style_o(alt_cpu_style_o), .test_mode_o(), .phase2_o(phase2_o),
    .col_strobe_even_n_o(col_strobe_even_n_o),
    .col_strobe_odd_n_o(col_strobe_odd_n_o),
    .row_strobes_low_n_o(row_strobes_low_n_o),
    .top_addr_or_row_strobe3_o(), .mem_row_col_addr_o(),
    .write_low_byte_n_o(write_low_byte_n_o),
    .write_high_byte_n_o(write_high_byte_n_o),
    .bank_out_or_transfer_n_o(bank_out_or_transfer_n_o)
  );
  ghb_host_model i_host (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .bus_hold_request_i(bus_hold_request_o),
    .master_enable_i(master_enable_o), .withhold_i(withhold),
    .drop_grant_i(drop_grant), .grant_delay_i(grant_delay),
    .bus_hold_grant_o(bus_hold_grant_i), .ready_n_o(ready_n_i)
  );
  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [3:0] sel, input logic [31:0] dat);
    @(posedge clk_sys_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    do @(posedge clk_sys_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // ==========================================================
  // scenarios
  task automatic do_reset(input logic byte_high_enable_n, input logic mio);
    rst_n_i <= 1'b0;
    bhe_drv <= byte_high_enable_n;
    mio_drv <= mio;
    repeat (16) @(posedge clk_sys_i);
    chk({phase2_o, bus_hold_request_o, master_enable_o, slave_enable_o,
         interrupt_out_o}, 5'h10);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    // pins move after the strap edge; selection must not follow
    bhe_drv <= ~byte_high_enable_n;
    mio_drv <= ~mio;
    repeat (4) @(posedge clk_sys_i);
    chk({sync_mode_o, alt_cpu_style_o}, {byte_high_enable_n, mio});
    wb(1'b0, 8'h04, 4'hF, 32'h0);
    chk(rd[5:2], {2'h3, mio, byte_high_enable_n});
    wb(1'b0, 8'h40, 4'hF, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic t_irq(input logic disp);
    @(posedge clk_sys_i);
    drawing_engine_irq_i <= !disp;
    display_engine_irq_i <= disp;
    @(posedge clk_sys_i);
    drawing_engine_irq_i <= 1'b0;
    display_engine_irq_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    chk(interrupt_out_o, 1'b1);
    wb(1'b0, 8'h04, 4'hF, 32'h0);
    chk(rd[0], 1'b1);
    wb(1'b0, 8'h00, 4'hF, 32'h0);
    repeat (2) @(posedge clk_sys_i);
    chk(interrupt_out_o, 1'b0);
  endtask
  task automatic t_slave(input logic write);
    int i;
    logic [4:0] seen;
    seen = 5'h00;
    @(posedge clk_sys_i);
    addr_drv <= 22'h000102;
    bhe_drv <= 1'b0;
    chip_select_n_i <= 1'b0;
    if (write) wr_drv <= 1'b0;
    else rd_drv <= 1'b0;
    for (i = 0; i < 40 && slave_enable_o !== 1'b1; i++) begin
      @(posedge clk_sys_i);
      chk(col_strobe_even_n_o, col_strobe_odd_n_o);
      seen = seen | {~row_strobes_low_n_o[0], ~&bank_out_or_transfer_n_o,
                     ~col_strobe_even_n_o, ~write_high_byte_n_o,
                     ~write_low_byte_n_o};
    end
    chk({slave_enable_o, master_enable_o}, 2'b10);
    chip_select_n_i <= 1'b1;
    rd_drv <= 1'b1;
    wr_drv <= 1'b1;
    bhe_drv <= 1'b1;
    for (i = 0; i < 8 && slave_enable_o !== 1'b0; i++) @(posedge clk_sys_i);
    chk(slave_enable_o, 1'b0);
    chk(seen, write ? 5'b10111 : 5'b11100);
  endtask
  task automatic t_master(input logic narrow, input logic hold_off,
                          input logic lose);
    int i;
    withhold <= hold_off;
    wb(1'b1, 8'h08, 4'hF, 32'h0012_3456);
    wb(1'b1, 8'h0C, 4'hF, 32'h0000_A5C3);
    if (narrow) begin
      wb(1'b1, 8'h00, 4'h1, 32'h7);
      repeat (4) @(posedge clk_sys_i);
      chk(bus_hold_request_o, 1'b0);
      wb(1'b1, 8'h00, 4'h2, 32'h0);
    end else begin
      wb(1'b1, 8'h00, 4'hF, 32'h7);
    end
    repeat (3) @(posedge clk_sys_i);
    chk(bus_hold_request_o, 1'b1);
    if (hold_off) begin
      t_slave(1'b0);
      withhold <= 1'b0;
    end
    for (i = 0; i < 40 && master_enable_o !== 1'b1; i++) @(posedge clk_sys_i);
    @(posedge clk_sys_i);
    chk({host_addr_oe_o, host_addr_o}, {1'b1, 22'h123456});
    chk({host_data_oe_o, host_data_o}, 17'h1A5C3);
    chk({byte_high_enable_n_oe_o, byte_high_enable_n_o,
         mem_or_io_select_oe_o, mem_or_io_select_o, strobe_oe_o,
         read_strobe_n_o, write_strobe_n_o}, 7'b1011110);
    if (lose) begin
      drop_grant <= 1'b1;
      for (i = 0; i < 8 && bus_hold_request_o; i++) @(posedge clk_sys_i);
      chk(bus_hold_request_o, 1'b0);
      drop_grant <= 1'b0;
      repeat (20) @(posedge clk_sys_i);
    end
    for (i = 0; i < 60 && bus_hold_request_o; i++) @(posedge clk_sys_i);
    repeat (3) @(posedge clk_sys_i);
    chk({master_enable_o, host_addr_oe_o}, 2'b00);
    wb(1'b0, 8'h04, 4'hF, 32'h0);
    if (!lose) chk(rd[1], 1'b1);
  endtask
  // ==========================================================
  // main sequence and hang guard
  initial begin
    do_reset(1'b1, 1'b0);
    t_irq(1'b0);
    t_irq(1'b1);
    t_master(1'b1, 1'b0, 1'b0);
    t_slave(1'b1);
    t_master(1'b0, 1'b1, 1'b0);
    grant_delay <= 4'h0;
    t_master(1'b0, 1'b0, 1'b1);
    do_reset(1'b0, 1'b1);
    t_slave(1'b0);
    end_of_test();
  end
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      end_of_test();
    end
  end
endmodule
bind ghb_host_bus ghb_host_bus_sva i_sva (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .chip_select_n_i(chip_select_n_i),
  .read_strobe_n_i(read_strobe_n_i), .write_strobe_n_i(write_strobe_n_i),
  .bus_hold_grant_i(bus_hold_grant_i),
  .bus_hold_request_o(bus_hold_request_o),
  .master_enable_o(master_enable_o), .slave_enable_o(slave_enable_o),
  .host_addr_oe_o(host_addr_oe_o), .strobe_oe_o(strobe_oe_o),
  .drawing_engine_irq_i(drawing_engine_irq_i),
  .display_engine_irq_i(display_engine_irq_i),
  .interrupt_out_o(interrupt_out_o), .phase2_o(phase2_o),
  .sync_mode_o(sync_mode_o), .alt_cpu_style_o(alt_cpu_style_o)
);
`default_nettype wire
